// [serial_channel_regs.svh]
/*
 register offsets, field positions, reset values and timing counts for
 the serial channel; assumes a 32-bit apb bus with word-aligned registers.
*/
`ifndef SERIAL_CHANNEL_REGS_SVH
`define SERIAL_CHANNEL_REGS_SVH
// printed offsets are register indices; byte address is index times four
`define SC_IDX_STATUS 12'h209
`define SC_IDX_MODE0 12'h20A
`define SC_IDX_BAUD 12'h20B
`define SC_IDX_FRAC 12'h20C
`define SC_IDX_MODE1 12'h20D
`define SC_IDX_DATA 12'h20E
`define SC_IDX_IRQ_STAT 12'h20F
`define SC_IDX_IRQ_MASK 12'h210
// status/control fields
`define SC_ST_RX9 7
`define SC_ST_EVEN 6
`define SC_ST_PEN 5
`define SC_ST_OVR 4
`define SC_ST_PAR 3
`define SC_ST_FRM 2
`define SC_ST_EDGE 1
`define SC_ST_IOC 0
// mode0 fields
`define SC_M0_TX9 7
`define SC_M0_CTS 6
`define SC_M0_RXE 5
`define SC_M0_WU 4
// baud control fields
`define SC_BR_ADDE 6
// interrupt bits
`define SC_IRQ_TX 0
`define SC_IRQ_RX 1
`define SC_IRQ_ERR 2
// reset values
`define SC_RST_BYTE 8'h00
`define SC_RST_IRQ 3'h0
// prescaler taps: divide by 1, 4, 16, 32 from the 50 MHz clock
`define SC_PRE_T0 5'h00
`define SC_PRE_T2 5'h03
`define SC_PRE_T8 5'h0F
`define SC_PRE_T32 5'h1F
// oversampling for uart mode
`define SC_OVERSAMPLE 4'hF
// timer counter reset load; the counter wraps, so it triggers every 256 pclk cycles
`define SC_TIMER_DIV 8'hFF
`endif

// [serial_channel_pkg.sv]
/*
 types shared by the serial channel files; constants live in the header.
*/
package serial_channel_pkg;
   typedef enum logic [1:0] {
      MODE_IO = 2'h0,
      MODE_UART7 = 2'h1,
      MODE_UART8 = 2'h2,
      MODE_UART9 = 2'h3
   } mode_t;
   typedef enum logic [1:0] {
      SRC_TIMER = 2'h0,
      SRC_BAUD = 2'h1,
      SRC_SYS = 2'h2,
      SRC_PIN = 2'h3
   } clk_src_t;
   typedef struct packed {
      logic fraction_divide_enable;
      logic [1:0] prescale_select;
      logic [3:0] divisor_n;
      logic [3:0] fraction_k;
   } baud_cfg_t;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA = 4'b0100,
      TX_STOP = 4'b1000
   } tx_state_t;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;
endpackage

// [serial_baud_gen.sv]
/*
 baud rate generator: prescaler tap, divide by n, optional (16-k)/16.
 assumes one pclk domain; the output is a one-cycle enable pulse.
*/
`timescale 1ns/1ns
`include "serial_channel_regs.svh"
module serial_baud_gen (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // configuration
   input wire serial_channel_pkg::baud_cfg_t cfg,
   // output tick
   output logic tick
);
   logic [4:0] pre_r, pre_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [3:0] acc_r, acc_nxt;
   logic tick_r, tick_nxt;
   logic [4:0] pre_top;
   logic [4:0] acc_sum;

   // next-state for prescaler, divisor and fraction accumulator
   always_comb begin
      unique case (cfg.prescale_select)
         2'h0: pre_top = `SC_PRE_T0;
         2'h1: pre_top = `SC_PRE_T2;
         2'h2: pre_top = `SC_PRE_T8;
         2'h3: pre_top = `SC_PRE_T32;
      endcase
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      tick_nxt = 1'b0;
      // the accumulator grows by 16-k mod 16, so a carry comes (16-k) times in 16; k of 0 never carries
      acc_sum = {1'b0, acc_r} + {1'b0, 4'h0 - cfg.fraction_k};
      if (pre_r >= pre_top) begin
         pre_nxt = 5'h00;
         // n of 0 or 1 ticks every input period; a carry adds one period when n is not 0
         if (cnt_r <= 4'h1) begin
            if (cfg.fraction_divide_enable && cnt_r == 4'h1 &&
                acc_sum[4]) begin
               cnt_nxt = 4'h0;
               acc_nxt = acc_sum[3:0];
            end else begin
               tick_nxt = 1'b1;
               cnt_nxt = cfg.divisor_n;
               if (cfg.fraction_divide_enable && !acc_sum[4])
                  acc_nxt = acc_sum[3:0];
            end
         end else begin
            cnt_nxt = cnt_r - 4'h1;
         end
      end else begin
         pre_nxt = pre_r + 5'h01;
      end
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= 5'h00;
         cnt_r <= 4'h0;
         acc_r <= 4'h0;
         tick_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule // serial_baud_gen

// [serial_channel_uart_sio.sv]
/*
 serial channel: uart (7/8/9 bit) or clocked i/o shift channel with apb
 registers and one level interrupt. assumes pins come from outside the
 pclk domain and are synchronised here.
*/
`timescale 1ns/1ns
`include "serial_channel_regs.svh"
module serial_channel_uart_sio (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rxd,
   output logic txd,
   input wire logic cts_n,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   // interrupt
   output logic irq
);
   logic [7:0] st_r, st_nxt, m0_r, m0_nxt, br_r, br_nxt;
   logic [7:0] fk_r, fk_nxt, m1_r, m1_nxt;
   logic [7:0] txb_r, txb_nxt, rxb_r, rxb_nxt;
   logic [2:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
   logic txd_r, txd_nxt, sck_r, sck_nxt, sckoe_r, sckoe_nxt;
   logic [2:0] rx_s, sk_s, ct_s;
   logic [7:0] tdiv_r, tdiv_nxt;
   logic [3:0] os_r, os_nxt, rs_r, rs_nxt;
   logic [3:0] tb_r, tb_nxt, rb_r, rb_nxt;
   logic [8:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
   logic tpar_r, tpar_nxt, rpar_r, rpar_nxt, tbusy_r, tbusy_nxt;
   logic rfull_r, rfull_nxt;
   serial_channel_pkg::tx_state_t ts_r, ts_nxt;
   serial_channel_pkg::rx_state_t rst_r, rst_nxt;
   serial_channel_pkg::baud_cfg_t bcfg;
   serial_channel_pkg::mode_t mode;
   serial_channel_pkg::clk_src_t src;
   logic baud_tick, clk_tick, io_mode, acc, wr, rd;
   logic [11:0] idx;
   logic [3:0] nbits;
   logic pin_rise, pin_fall, rx_lvl, ck_lvl, cts_ok, sh_edge, smp_edge;
   logic [2:0] ev;
   logic [4:2] eset;

   assign acc = psel && penable && !pready_r;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign idx = paddr[13:2];
   assign mode = serial_channel_pkg::mode_t'(m0_r[3:2]);
   assign src = serial_channel_pkg::clk_src_t'(m0_r[1:0]);
   assign io_mode = (mode == serial_channel_pkg::MODE_IO);
   assign bcfg = '{fraction_divide_enable: br_r[`SC_BR_ADDE],
                   prescale_select: br_r[5:4], divisor_n: br_r[3:0],
                   fraction_k: fk_r[3:0]};
   assign rx_lvl = rx_s[2];
   assign ck_lvl = sk_s[2];
   // change counts when the second stage differs from the third
   assign pin_rise = sk_s[1] && !sk_s[2];
   assign pin_fall = !sk_s[1] && sk_s[2];
   assign cts_ok = !m0_r[`SC_M0_CTS] || !ct_s[2];

   serial_baud_gen u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(bcfg),
      .tick(baud_tick)
   );

   // bit clock source select
   always_comb begin
      unique case (src)
         serial_channel_pkg::SRC_TIMER: clk_tick = (tdiv_r == 8'h00);
         serial_channel_pkg::SRC_BAUD: clk_tick = baud_tick;
         serial_channel_pkg::SRC_SYS: clk_tick = 1'b1;
         serial_channel_pkg::SRC_PIN: clk_tick = pin_rise;
      endcase
      nbits = (mode == serial_channel_pkg::MODE_UART7) ? 4'h7 :
              (mode == serial_channel_pkg::MODE_UART9) ? 4'h9 : 4'h8;
   end

   // io mode shift/sample edges: internal clock or pin, per edge select
   always_comb begin
      if (st_r[`SC_ST_IOC]) begin
         sh_edge = st_r[`SC_ST_EDGE] ? pin_rise : pin_fall;
         smp_edge = st_r[`SC_ST_EDGE] ? pin_fall : pin_rise;
      end else begin
         sh_edge = baud_tick && sck_r;
         smp_edge = baud_tick && !sck_r;
      end
   end

   // transmit and receive machines, apb registers, interrupt
   always_comb begin
      st_nxt = st_r; m0_nxt = m0_r; br_nxt = br_r; fk_nxt = fk_r;
      m1_nxt = m1_r; txb_nxt = txb_r; rxb_nxt = rxb_r;
      ist_nxt = ist_r; imsk_nxt = imsk_r;
      prdata_nxt = prdata_r; pready_nxt = 1'b0; pslverr_nxt = 1'b0;
      txd_nxt = txd_r; sck_nxt = sck_r; sckoe_nxt = 1'b0;
      tdiv_nxt = tdiv_r - 8'h01;
      os_nxt = os_r; rs_nxt = rs_r; tb_nxt = tb_r; rb_nxt = rb_r;
      tsh_nxt = tsh_r; rsh_nxt = rsh_r; tpar_nxt = tpar_r;
      rpar_nxt = rpar_r; tbusy_nxt = tbusy_r; rfull_nxt = rfull_r;
      ts_nxt = ts_r; rst_nxt = rst_r; ev = 3'h0; eset = 3'h0;
      // internal clock drives the pin in io mode while the ioc bit is clear, pin input otherwise
      if (io_mode && !st_r[`SC_ST_IOC]) begin
         sckoe_nxt = 1'b1;
         if (baud_tick && ts_r != serial_channel_pkg::TX_IDLE)
            sck_nxt = !sck_r;
         else if (ts_r == serial_channel_pkg::TX_IDLE)
            sck_nxt = 1'b1;
      end
      if (io_mode) begin
         // clocked shift, 8 bits lsb first; output shifts on sh_edge
         unique case (ts_r)
            serial_channel_pkg::TX_IDLE:
               if (tbusy_r && cts_ok) begin
                  tsh_nxt = {1'b0, txb_r}; tb_nxt = 4'h0; tbusy_nxt = 1'b0;
                  txd_nxt = txb_r[0];
                  ts_nxt = serial_channel_pkg::TX_DATA;
               end
            serial_channel_pkg::TX_DATA: begin
               if (smp_edge && m0_r[`SC_M0_RXE])
                  rsh_nxt = {1'b0, rx_lvl, rsh_r[7:1]};
               if (sh_edge) begin
                  tsh_nxt = {1'b0, tsh_r[8:1]};
                  txd_nxt = tsh_r[1];
                  tb_nxt = tb_r + 4'h1;
                  if (tb_r == 4'h7) begin
                     ts_nxt = serial_channel_pkg::TX_IDLE;
                     txd_nxt = 1'b1;
                     ev[`SC_IRQ_TX] = 1'b1;
                     if (m0_r[`SC_M0_RXE]) begin
                        if (rfull_r) eset[`SC_ST_OVR] = 1'b1;
                        rxb_nxt = rsh_r[7:0]; rfull_nxt = 1'b1;
                        ev[`SC_IRQ_RX] = 1'b1;
                     end
                  end
               end
            end
            default: ts_nxt = serial_channel_pkg::TX_IDLE;
         endcase
      end else begin
         // uart transmitter, one bit per 16 clock ticks
         if (clk_tick) os_nxt = os_r + 4'h1;
         if (clk_tick && os_r == `SC_OVERSAMPLE) begin
            unique case (ts_r)
               serial_channel_pkg::TX_IDLE:
                  if (tbusy_r && cts_ok) begin
                     tsh_nxt = {m0_r[`SC_M0_TX9], txb_r};
                     tbusy_nxt = 1'b0; txd_nxt = 1'b0; tb_nxt = 4'h0;
                     tpar_nxt = !st_r[`SC_ST_EVEN];
                     ts_nxt = serial_channel_pkg::TX_START;
                  end
               serial_channel_pkg::TX_START, serial_channel_pkg::TX_DATA:
                  if (tb_r < nbits) begin
                     txd_nxt = tsh_r[0]; tpar_nxt = tpar_r ^ tsh_r[0];
                     tsh_nxt = {1'b0, tsh_r[8:1]};
                     tb_nxt = tb_r + 4'h1;
                     ts_nxt = serial_channel_pkg::TX_DATA;
                  end else if (st_r[`SC_ST_PEN] && tb_r == nbits) begin
                     txd_nxt = tpar_r; tb_nxt = tb_r + 4'h1;
                  end else begin
                     txd_nxt = 1'b1;
                     ts_nxt = serial_channel_pkg::TX_STOP;
                  end
               serial_channel_pkg::TX_STOP: begin
                  ts_nxt = serial_channel_pkg::TX_IDLE;
                  ev[`SC_IRQ_TX] = 1'b1;
               end
            endcase
         end
         // uart receiver, samples mid bit
         if (clk_tick) begin
            rs_nxt = rs_r + 4'h1;
            unique case (rst_r)
               serial_channel_pkg::RX_IDLE:
                  if (!rx_lvl && m0_r[`SC_M0_RXE]) begin
                     rs_nxt = 4'h0; rb_nxt = 4'h0;
                     rpar_nxt = !st_r[`SC_ST_EVEN];
                     rst_nxt = serial_channel_pkg::RX_START;
                  end
               serial_channel_pkg::RX_START:
                  if (rs_r == 4'h7) begin
                     rs_nxt = 4'h0;
                     rst_nxt = rx_lvl ? serial_channel_pkg::RX_IDLE :
                                        serial_channel_pkg::RX_DATA;
                  end
               serial_channel_pkg::RX_DATA:
                  if (rs_r == `SC_OVERSAMPLE) begin
                     rb_nxt = rb_r + 4'h1;
                     if (rb_r < nbits) begin
                        rsh_nxt = {rx_lvl, rsh_r[8:1]};
                        rpar_nxt = rpar_r ^ rx_lvl;
                     end else if (st_r[`SC_ST_PEN] && rb_r == nbits) begin
                        if (rpar_r != rx_lvl)
                           eset[`SC_ST_PAR] = 1'b1;
                     end else begin
                        rst_nxt = serial_channel_pkg::RX_STOP;
                     end
                  end
               serial_channel_pkg::RX_STOP: begin
                  rst_nxt = serial_channel_pkg::RX_IDLE;
                  if (!rx_lvl) eset[`SC_ST_FRM] = 1'b1;
                  // justify frame, keep the ninth bit separately
                  unique case (mode)
                     serial_channel_pkg::MODE_UART7:
                        rxb_nxt = {1'b0, rsh_r[8:2]};
                     serial_channel_pkg::MODE_UART9: begin
                        rxb_nxt = rsh_r[7:0];
                        st_nxt[`SC_ST_RX9] = rsh_r[8];
                     end
                     default: rxb_nxt = rsh_r[8:1];
                  endcase
                  if (!(m0_r[`SC_M0_WU] &&
                        mode == serial_channel_pkg::MODE_UART9 &&
                        !rsh_r[8])) begin
                     if (rfull_r) eset[`SC_ST_OVR] = 1'b1;
                     rfull_nxt = 1'b1;
                     ev[`SC_IRQ_RX] = 1'b1;
                  end else begin
                     rxb_nxt = rxb_r;
                  end
               end
            endcase
         end
      end
      // error flags are sticky until a status read
      st_nxt[4:2] = st_r[4:2] | eset;
      if (|eset) ev[`SC_IRQ_ERR] = 1'b1;
      // apb access: one wait state, answer on the second cycle
      if (acc) begin
         pready_nxt = 1'b1;
         prdata_nxt = 32'h0000_0000;
         unique case (idx)
            `SC_IDX_STATUS: if (wr) begin
                  st_nxt[6:5] = pwdata[6:5];
                  st_nxt[1:0] = pwdata[1:0];
               end else begin
                  prdata_nxt[7:0] = st_r;
                  // an error in the clearing cycle survives: set wins
                  st_nxt[4:2] = eset;
               end
            `SC_IDX_MODE0: if (wr) m0_nxt = pwdata[7:0];
               else prdata_nxt[7:0] = m0_r;
            `SC_IDX_BAUD: if (wr) br_nxt = {1'b0, pwdata[6:0]};
               else prdata_nxt[7:0] = br_r;
            `SC_IDX_FRAC: if (wr) fk_nxt = {4'h0, pwdata[3:0]};
               else prdata_nxt[7:0] = fk_r;
            `SC_IDX_MODE1: if (wr) m1_nxt = {pwdata[7:6], 6'h00};
               else prdata_nxt[7:0] = m1_r;
            `SC_IDX_DATA: if (wr) begin
                  txb_nxt = pwdata[7:0]; tbusy_nxt = 1'b1;
               end else begin
                  prdata_nxt[7:0] = rxb_r; rfull_nxt = 1'b0;
               end
            `SC_IDX_IRQ_STAT: if (rd) begin
                  prdata_nxt[2:0] = ist_r; ist_nxt = 3'h0;
               end
            `SC_IDX_IRQ_MASK: if (wr) imsk_nxt = pwdata[2:0];
               else prdata_nxt[2:0] = imsk_r;
            default: pslverr_nxt = 1'b1;
         endcase
      end
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & imsk_nxt);
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= `SC_RST_BYTE; m0_r <= `SC_RST_BYTE; br_r <= `SC_RST_BYTE;
         fk_r <= `SC_RST_BYTE; m1_r <= `SC_RST_BYTE;
         txb_r <= `SC_RST_BYTE; rxb_r <= `SC_RST_BYTE;
         ist_r <= `SC_RST_IRQ; imsk_r <= `SC_RST_IRQ;
         prdata_r <= 32'h0000_0000; pready_r <= 1'b0; pslverr_r <= 1'b0;
         irq_r <= 1'b0; txd_r <= 1'b1; sck_r <= 1'b1; sckoe_r <= 1'b0;
         rx_s <= 3'h7; sk_s <= 3'h7; ct_s <= 3'h7;
         tdiv_r <= `SC_TIMER_DIV; os_r <= 4'h0; rs_r <= 4'h0;
         tb_r <= 4'h0; rb_r <= 4'h0; tsh_r <= 9'h000; rsh_r <= 9'h000;
         tpar_r <= 1'b0; rpar_r <= 1'b0; tbusy_r <= 1'b0;
         rfull_r <= 1'b0;
         ts_r <= serial_channel_pkg::TX_IDLE;
         rst_r <= serial_channel_pkg::RX_IDLE;
      end else begin
         st_r <= st_nxt; m0_r <= m0_nxt; br_r <= br_nxt;
         fk_r <= fk_nxt; m1_r <= m1_nxt;
         txb_r <= txb_nxt; rxb_r <= rxb_nxt;
         ist_r <= ist_nxt; imsk_r <= imsk_nxt;
         prdata_r <= prdata_nxt; pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt; irq_r <= irq_nxt;
         txd_r <= txd_nxt; sck_r <= sck_nxt; sckoe_r <= sckoe_nxt;
         rx_s <= {rx_s[1:0], rxd};
         sk_s <= {sk_s[1:0], serial_clock_pin_in};
         ct_s <= {ct_s[1:0], cts_n};
         tdiv_r <= tdiv_nxt; os_r <= os_nxt; rs_r <= rs_nxt;
         tb_r <= tb_nxt; rb_r <= rb_nxt; tsh_r <= tsh_nxt;
         rsh_r <= rsh_nxt; tpar_r <= tpar_nxt; rpar_r <= rpar_nxt;
         tbusy_r <= tbusy_nxt; rfull_r <= rfull_nxt;
         ts_r <= ts_nxt; rst_r <= rst_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign txd = txd_r;
   assign serial_clock_pin_out = sck_r;
   assign serial_clock_pin_oe = sckoe_r;
endmodule // serial_channel_uart_sio

// [serial_channel_checker_assertions.sv]
/*
 port-level checker for the serial channel.
 assumes one pclk domain with async active-low presetn.
*/
`timescale 1ns/1ns
`include "serial_channel_regs.svh"
module serial_channel_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // line and interrupt
   input wire logic txd,
   input wire logic serial_clock_pin_oe,
   input wire logic irq
);
   logic mapped;
   // decode of the word index the bus is pointing at
   assign mapped = paddr[13:2] >= `SC_IDX_STATUS &&
      paddr[13:2] <= `SC_IDX_IRQ_MASK;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_one_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("late pready");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
   property p_ready_cause;
      pready |-> $past(psel) && $past(penable) && psel;
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
   property p_idle_quiet;
      !psel |-> !pready && !pslverr;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("answer when idle");
   property p_bad_index;
      pready && !mapped |-> pslverr;
   endproperty
   a_bad_index: assert property (p_bad_index) else $error("no slverr");
   property p_good_index;
      pready && mapped |-> !pslverr;
   endproperty
   a_good_index: assert property (p_good_index) else $error("wrong slverr");
   property p_upper_zero;
      pready && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   // an apb access (irq status read or mask write) is the only thing that may drop the interrupt
   property p_irq_drop;
      $fell(irq) |-> $past(psel) || $past(psel, 2) || $past(psel, 3);
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq fell alone");
   property p_reset_vals;
      $rose(presetn) |-> txd && !irq && !serial_clock_pin_oe;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
   c_slverr: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
   c_frame: cover property ($fell(txd));
endmodule // serial_channel_checker
bind serial_channel_uart_sio serial_channel_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txd(txd),
   .serial_clock_pin_oe(serial_clock_pin_oe), .irq(irq));

// [uart_peer.sv]
/*
 remote uart on the line side: lsb first, one stop bit.
 assumes 16 pclk per bit, i.e. the channel clocked from the system clock.
*/
`timescale 1ns/1ns
module uart_peer #(parameter int BIT = 16) (
   // clock
   input wire logic pclk,
   // line
   input wire logic txd,
   output logic rxd
);
   // line idles high between frames
   initial rxd = 1'h1;
   // sample each bit in its middle
   task automatic recv(input int n, output logic [8:0] d);
      d = 9'h000;
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(posedge pclk);
         d[i] = txd;
      end
      repeat (BIT) @(posedge pclk);
   endtask
   // stop level is a choice so a broken frame can be sent
   task automatic send(input int n, input logic [8:0] d, input logic stop);
      @(posedge pclk);
      rxd <= 1'h0;
      repeat (BIT) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         rxd <= d[i];
         repeat (BIT) @(posedge pclk);
      end
      rxd <= stop;
      repeat (BIT) @(posedge pclk);
      rxd <= 1'h1;
      repeat (BIT) @(posedge pclk);
   endtask
endmodule // uart_peer

// [tb_top.sv]
/*
 testbench for the serial channel: apb tasks, uart frames both ways,
 error flags, interrupt masking, wakeup and handshake gating.
*/
`timescale 1ns/1ns
`include "serial_channel_regs.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, r, x;
   logic rxd, txd, cts_n, irq, e;
   logic [8:0] got;
   logic [7:0] d;
   int fail_count, compares, nb;
   logic [7:0] m0 [5] = '{8'h26, 8'h2A, 8'hAE, 8'h2A, 8'h2A};
   logic [7:0] st [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h60};
   logic [7:0] rs [3] = '{8'h00, 8'h20, 8'h00};
   logic [7:0] rf [3] = '{8'h00, 8'h08, 8'h04};
   serial_channel_uart_sio u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n),
      .serial_clock_pin_in(1'h1), .serial_clock_pin_out(),
      .serial_clock_pin_oe(), .irq(irq));
   uart_peer u_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
   task chk(input logic [31:0] g, input logic [31:0] xp);
      compares++;
      if (g !== xp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, xp);
      end
   endtask
   // one apb transfer; held until pready is seen at a rising edge
   task acc(input logic w, input logic [11:0] i, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rdc(input logic [11:0] i, input logic [31:0] m, input logic [31:0] xp);
      acc(1'h0, i, 32'h0);
      chk(r & m, xp);
   endtask
   task wirq;
      int n;
      n = 0;
      while (irq !== 1'h1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk(irq, 1'h1);
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // free-running 50 MHz clock
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   // a hang ends the run with a mismatch counted
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      give_verdict;
   end
   // main sequence
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      cts_n = 1'h0;
      fail_count = 0;
      compares = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      for (int i = `SC_IDX_STATUS; i <= `SC_IDX_IRQ_MASK; i++)
         if (i != `SC_IDX_DATA) rdc(i, 32'hFFFFFF7F, 32'h0);
      acc(1'h0, 12'h211, 32'h0);
      chk(e, 1'h1);
      acc(1'h1, `SC_IDX_BAUD, 32'h3F);
      rdc(`SC_IDX_BAUD, 32'h7F, 32'h3F);
      acc(1'h1, `SC_IDX_FRAC, 32'h0F);
      rdc(`SC_IDX_FRAC, 32'h0F, 32'h0F);
      acc(1'h1, `SC_IDX_STATUS, 32'h63);
      rdc(`SC_IDX_STATUS, 32'h63, 32'h63);
      acc(1'h1, `SC_IDX_IRQ_MASK, 32'h7);
      $display("test registers done");
      // 7, 8, 9 bit frames, then 8 bit with odd and even parity
      for (int k = 0; k < 5; k++) begin
         acc(1'h1, `SC_IDX_MODE0, {24'h0, m0[k]});
         acc(1'h1, `SC_IDX_STATUS, {24'h0, st[k]});
         d = 8'h96 ^ {5'h00, k[2:0]};
         nb = k == 0 ? 7 : (k == 1 ? 8 : 9);
         case (k)
            0: x = {25'h0, d[6:0]};
            1: x = {24'h0, d};
            2: x = {23'h0, 1'h1, d};
            3: x = {23'h0, ~^d, d};
            default: x = {23'h0, ^d, d};
         endcase
         fork
            u_peer.recv(nb, got);
            acc(1'h1, `SC_IDX_DATA, {24'h0, d});
         join
         chk({23'h0, got}, x);
      end
      wirq;
      rdc(`SC_IDX_IRQ_STAT, 32'h1, 32'h1);
      repeat (3) @(posedge pclk);
      chk(irq, 1'h0);
      $display("test transmit done");
      // good frame, parity error, framing error
      for (int k = 0; k < 3; k++) begin
         acc(1'h1, `SC_IDX_STATUS, {24'h0, rs[k]});
         u_peer.send(k == 1 ? 9 : 8, 9'h0C3, k != 2);
         wirq;
         rdc(`SC_IDX_DATA, 32'hFF, 32'hC3);
         rdc(`SC_IDX_STATUS, 32'h1C, {24'h0, rf[k]});
         rdc(`SC_IDX_STATUS, 32'h1C, 32'h0);
         acc(1'h0, `SC_IDX_IRQ_STAT, 32'h0);
      end
      // masked overrun, then unmask the pending receive event
      acc(1'h1, `SC_IDX_IRQ_MASK, 32'h0);
      u_peer.send(8, 9'h0C3, 1'h1);
      u_peer.send(8, 9'h05A, 1'h1);
      repeat (20) @(posedge pclk);
      chk(irq, 1'h0);
      rdc(`SC_IDX_STATUS, 32'h10, 32'h10);
      acc(1'h1, `SC_IDX_IRQ_MASK, 32'h2);
      wirq;
      rdc(`SC_IDX_IRQ_STAT, 32'h2, 32'h2);
      repeat (3) @(posedge pclk);
      chk(irq, 1'h0);
      $display("test receive done");
      // wakeup: only a frame with the ninth bit set is taken
      acc(1'h0, `SC_IDX_DATA, 32'h0);
      acc(1'h1, `SC_IDX_MODE0, 32'h3E);
      acc(1'h1, `SC_IDX_STATUS, 32'h0);
      u_peer.send(9, 9'h011, 1'h1);
      repeat (20) @(posedge pclk);
      chk(irq, 1'h0);
      u_peer.send(9, 9'h122, 1'h1);
      wirq;
      rdc(`SC_IDX_DATA, 32'hFF, 32'h22);
      rdc(`SC_IDX_STATUS, 32'h80, 32'h80);
      $display("test wakeup done");
      // handshake gate holds the line idle until cts_n falls
      // bit clock from the generator: finest tap, n of 1, no fraction
      acc(1'h1, `SC_IDX_BAUD, 32'h01);
      acc(1'h1, `SC_IDX_MODE0, 32'h69);
      cts_n <= 1'h1;
      acc(1'h1, `SC_IDX_DATA, 32'h3C);
      repeat (200) @(posedge pclk);
      chk(txd, 1'h1);
      fork
         u_peer.recv(8, got);
         cts_n <= 1'h0;
      join
      chk({23'h0, got}, 32'h3C);
      $display("test handshake done");
      give_verdict;
   end
endmodule // tb_top
